//--- shared/fmsp_defs.svh
// Offsets, field positions, load values and counts of the serial port.
// Assumes a 32-bit AXI4-Lite slave with a 4-bit byte address.
`ifndef FMSP_DEFS_SVH
`define FMSP_DEFS_SVH
// Register byte addresses
`define FMSP_ADDR_DATA 4'h0
`define FMSP_ADDR_CTRL 4'h4
`define FMSP_ADDR_RATE 4'h8
// serial_control_reg bit positions
`define FMSP_CTL_MODEH 7
`define FMSP_CTL_MODEL 6
`define FMSP_CTL_MP 5
`define FMSP_CTL_REN 4
`define FMSP_CTL_TB8 3
`define FMSP_CTL_RB8 2
`define FMSP_CTL_TI 1
`define FMSP_CTL_RI 0
// serial_rate_reg bit positions
`define FMSP_RATE_DBL 0
`define FMSP_RATE_TSEL 1
// Machine cycle: twelve oscillator clocks, shift clock low in first half
`define FMSP_MC_LAST 4'hB
`define FMSP_MC_HALF 4'h6
// Divide-by-16 counter last state and majority sample states
`define FMSP_CNT_LAST 4'hF
`define FMSP_SMP_FIRST 4'h7
`define FMSP_SMP_LAST 4'h9
// Receive shift register load values
`define FMSP_RX0_INIT 8'hFE
`define FMSP_RX_INIT 9'h1FF
// Bus answers
`define FMSP_RESP_OKAY 2'h0
`define FMSP_RESP_SLVERR 2'h2
`endif

//--- shared/fmsp_pkg.sv
// Types of the four-mode serial port: modes, states, carriers.
// Assumes fmsp_defs.svh supplies the numeric constants.
package fmsp_pkg;
	typedef enum logic [1:0] {FMSP_SYNC, FMSP_ASYNC8, FMSP_FIXED9, FMSP_VAR9} fmsp_mode_e;
	typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_STOP} fmsp_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_LOAD, RX_SHIFT, RX_BIT} fmsp_rx_e;
	typedef struct packed {
		logic awvalid; logic [3:0] awaddr; logic wvalid; logic [31:0] wdata;
		logic [3:0] wstrb; logic bready; logic arvalid; logic [3:0] araddr; logic rready;
	} fmsp_axi_req_s;
	typedef struct packed {
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} fmsp_axi_rsp_s;
	typedef struct packed {
		logic port_three_line_zero_out; logic port_three_line_zero_oe; logic port_three_line_one_out;
	} fmsp_pins_s;
	typedef struct packed {
		fmsp_axi_rsp_s rsp; fmsp_pins_s pins;
		logic aw_have; logic [3:0] awaddr; logic w_have; logic [7:0] wdata; logic wstb;
		logic [7:0] rxbuf; fmsp_mode_e mode; logic mp; logic ren; logic tb8; logic rb8;
		logic ti; logic ri; logic dbl; logic tsel;
		logic [3:0] div12; logic [1:0] presc;
		fmsp_tx_e tx; logic [9:0] tx_sh; logic [3:0] tx_cnt;
		fmsp_rx_e rx; logic [9:0] rx_sh; logic [3:0] rx_cnt; logic [2:0] rx_smp;
		logic rx_first; logic rx_prev; logic rx_meta; logic rx_s;
	} fmsp_state_s;
endpackage

//--- src/fmsp_top.sv
// Four-mode serial port with an AXI4-Lite register slave.
// Assumes clk is the oscillator and timer overflows are one-cycle pulses on clk.
// Functional notes
// - Sync mode: buffer write starts transmit, marker one loaded above data.
// - Sync mode: send goes active one full machine cycle after the write.
// - While sending in sync mode, data drives line zero, shift clock line one.
// - Each sending machine cycle shifts transmit register right, zero fill.
// - Marker next to data MSB: last shift, stop send, set tx done, tenth cycle.
// - Sync receive starts on enable with rx done clear; loads 11111110, then active.
// - Active receive shifts left each machine cycle, sampled line zero entering right.
// - Loaded zero at leftmost: one last shift, byte goes to the data buffer.
// - Mode one frame: low start, eight data LSB first, high stop.
// - Mode one bit rate comes from one of two external timer overflows.
// - Async write loads marker; frame begins at next divide-by-16 rollover.
// - Start bit first, data output one bit later, first shift one bit after.
// - Async transmit shifts right with zero fill; one more shift at marker.
// - Input sampled at sixteen times rate; falling edge loads 1FF, clears counter.
// - Majority of states seven to nine; nonzero first bit restarts the hunt.
// - Start bit leftmost: last shift; store ninth, byte, done if allowed.
// - Otherwise frame dropped; either way hunting for falling edge resumes.
// - Nine-bit frame: start, eight data LSB first, ninth bit, high stop.
// - Nine-bit modes send the transmit ninth-bit flag as ninth data bit.
// - Nine-bit modes write the ninth bit of each stored frame into the status flag.
// - Fixed nine-bit mode runs at one 32nd or one 64th of oscillator.
// - Variable nine-bit mode equals fixed mode but rate from external timer.
// - Sync mode: shift clock on line one, eight bits LSB first, osc/12.
// - Doubler bit picks fixed-mode divisor; reset value zero gives osc/32.
// - Async transmit sets tx done after stop bit; software clears it.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_defs.svh"
module fmsp_top import fmsp_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire fmsp_axi_req_s axi_req,
	output fmsp_axi_rsp_s axi_rsp,
	// Serial lines
	input wire logic port_three_line_zero_in,
	output fmsp_pins_s pins,
	// External timer overflow pulses
	input wire logic tmr_a_ovf,
	input wire logic tmr_b_ovf
);
	fmsp_state_s st_r;
	fmsp_state_s st_nxt;
	logic mc, tick, roll, step, tx_last, nine;
	logic wr_go, wr_data, wr_ctrl;
	logic rx_bit, rx_fin, rx_ninth, store_ok;
	logic [7:0] rx_data;

	// Reverses a byte gathered MSB-side first
	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			rev8[i] = v[7 - i];
		end
	endfunction

	// Two-of-three vote
	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// Rate strobes: machine cycle, 16x tick, divide-by-16 rollover
	assign mc = (st_r.div12 == `FMSP_MC_LAST);
	always_comb begin
		unique case (st_r.mode)
			FMSP_SYNC: tick = 1'b0;
			FMSP_FIXED9: tick = st_r.presc[0] & (st_r.presc[1] | ~st_r.dbl);
			FMSP_ASYNC8, FMSP_VAR9: tick = st_r.tsel ? tmr_b_ovf : tmr_a_ovf;
		endcase
	end
	assign roll = tick && (st_r.tx_cnt == `FMSP_CNT_LAST);
	assign step = (st_r.mode == FMSP_SYNC) ? mc : roll;
	assign nine = st_r.mode[1];
	assign tx_last = (st_r.tx_sh[9:1] == 9'h001);

	// Receive frame end decode
	assign rx_bit = maj3(st_r.rx_smp);
	assign rx_fin = (st_r.rx == RX_BIT) && tick && (st_r.rx_cnt == `FMSP_CNT_LAST) && !st_r.rx_first
		&& (nine ? !st_r.rx_sh[9] : !st_r.rx_sh[8]);
	assign rx_data = nine ? rev8(st_r.rx_sh[8:1]) : rev8(st_r.rx_sh[7:0]);
	assign rx_ninth = nine ? st_r.rx_sh[0] : rx_bit;
	assign store_ok = !st_r.ri && (!st_r.mp || rx_ninth);

	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		wr_go = 1'b0;
		st_nxt.div12 = mc ? 4'h0 : st_r.div12 + 4'h1;
		st_nxt.presc = st_r.presc + 2'h1;
		st_nxt.rx_meta = port_three_line_zero_in;
		st_nxt.rx_s = st_r.rx_meta;
		if (tick) begin
			st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
			st_nxt.rx_prev = st_r.rx_s;
		end
		// Bus write: address and data taken in either order
		if (axi_req.awvalid && st_r.rsp.awready) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && st_r.rsp.wready) begin
			st_nxt.w_have = 1'b1;
			st_nxt.wdata = axi_req.wdata[7:0];
			st_nxt.wstb = axi_req.wstrb[0];
		end
		if (st_r.rsp.bvalid && axi_req.bready) begin
			st_nxt.rsp.bvalid = 1'b0;
		end
		if (st_nxt.aw_have && st_nxt.w_have && !st_r.rsp.bvalid) begin
			wr_go = 1'b1;
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have = 1'b0;
			st_nxt.rsp.bvalid = 1'b1;
			st_nxt.rsp.bresp = (st_nxt.awaddr == `FMSP_ADDR_DATA || st_nxt.awaddr == `FMSP_ADDR_CTRL
				|| st_nxt.awaddr == `FMSP_ADDR_RATE) ? `FMSP_RESP_OKAY : `FMSP_RESP_SLVERR;
		end
		wr_data = wr_go && st_nxt.wstb && (st_nxt.awaddr == `FMSP_ADDR_DATA);
		wr_ctrl = wr_go && st_nxt.wstb && (st_nxt.awaddr == `FMSP_ADDR_CTRL);
		// Control writes land first so hardware sets below win
		if (wr_ctrl) begin
			st_nxt.mode = fmsp_mode_e'({st_nxt.wdata[`FMSP_CTL_MODEH], st_nxt.wdata[`FMSP_CTL_MODEL]});
			st_nxt.mp = st_nxt.wdata[`FMSP_CTL_MP];
			st_nxt.ren = st_nxt.wdata[`FMSP_CTL_REN];
			st_nxt.tb8 = st_nxt.wdata[`FMSP_CTL_TB8];
			st_nxt.rb8 = st_nxt.wdata[`FMSP_CTL_RB8];
			st_nxt.ti = st_nxt.wdata[`FMSP_CTL_TI];
			st_nxt.ri = st_nxt.wdata[`FMSP_CTL_RI];
		end
		if (wr_go && st_nxt.wstb && st_nxt.awaddr == `FMSP_ADDR_RATE) begin
			st_nxt.dbl = st_nxt.wdata[`FMSP_RATE_DBL];
			st_nxt.tsel = st_nxt.wdata[`FMSP_RATE_TSEL];
		end
		// Bus read
		if (st_r.rsp.rvalid && axi_req.rready) begin
			st_nxt.rsp.rvalid = 1'b0;
		end
		if (axi_req.arvalid && st_r.rsp.arready) begin
			st_nxt.rsp.rvalid = 1'b1;
			st_nxt.rsp.rresp = `FMSP_RESP_OKAY;
			st_nxt.rsp.rdata = 32'h0000_0000;
			unique case (axi_req.araddr)
				`FMSP_ADDR_DATA: st_nxt.rsp.rdata[7:0] = st_r.rxbuf;
				`FMSP_ADDR_CTRL: st_nxt.rsp.rdata[7:0] = {st_r.mode, st_r.mp, st_r.ren, st_r.tb8,
					st_r.rb8, st_r.ti, st_r.ri};
				`FMSP_ADDR_RATE: st_nxt.rsp.rdata[1:0] = {st_r.tsel, st_r.dbl};
				default: st_nxt.rsp.rresp = `FMSP_RESP_SLVERR;
			endcase
		end
		st_nxt.rsp.awready = !st_nxt.aw_have && !st_nxt.rsp.bvalid;
		st_nxt.rsp.wready = !st_nxt.w_have && !st_nxt.rsp.bvalid;
		st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
		// Transmit control
		unique case (st_r.tx)
			TX_IDLE: ;
			TX_WAIT: if (step) begin
				st_nxt.tx = TX_START;
			end
			TX_START: if (step) begin
				st_nxt.tx = TX_DATA;
			end
			TX_DATA: if (step) begin
				st_nxt.tx_sh = {1'b0, st_r.tx_sh[9:1]};
				if (tx_last) begin
					if (st_r.mode == FMSP_SYNC) begin
						st_nxt.tx = TX_IDLE;
						st_nxt.ti = 1'b1;
					end else begin
						st_nxt.tx = TX_STOP;
					end
				end
			end
			TX_STOP: if (step) begin
				st_nxt.tx = TX_IDLE;
				st_nxt.ti = 1'b1;
			end
			default: st_nxt.tx = TX_IDLE;
		endcase
		if (wr_data) begin
			st_nxt.tx = TX_WAIT;
			st_nxt.tx_sh = nine ? {1'b1, st_nxt.tb8, st_nxt.wdata} : {2'b01, st_nxt.wdata};
		end
		// Receive control
		unique case (st_r.rx)
			RX_IDLE: if (st_r.ren) begin
				if (st_r.mode == FMSP_SYNC) begin
					if (!st_r.ri) begin
						st_nxt.rx = RX_LOAD;
					end
				end else if (tick && st_r.rx_prev && !st_r.rx_s) begin
					st_nxt.rx_sh = {1'b1, `FMSP_RX_INIT};
					st_nxt.rx_cnt = 4'h0;
					st_nxt.rx_first = 1'b1;
					st_nxt.rx = RX_BIT;
				end
			end
			RX_LOAD: if (mc) begin
				st_nxt.rx_sh = {2'b11, `FMSP_RX0_INIT};
				st_nxt.rx = RX_SHIFT;
			end
			RX_SHIFT: if (mc) begin
				st_nxt.rx_sh[7:0] = {st_r.rx_sh[6:0], st_r.rx_s};
				if (!st_r.rx_sh[7]) begin
					st_nxt.rxbuf = rev8({st_r.rx_sh[6:0], st_r.rx_s});
					st_nxt.ri = 1'b1;
					st_nxt.rx = RX_IDLE;
				end
			end
			RX_BIT: if (tick) begin
				st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
				if (st_r.rx_cnt >= `FMSP_SMP_FIRST && st_r.rx_cnt <= `FMSP_SMP_LAST) begin
					st_nxt.rx_smp = {st_r.rx_smp[1:0], st_r.rx_s};
				end
				if (st_r.rx_cnt == `FMSP_CNT_LAST) begin
					if (st_r.rx_first && rx_bit) begin
						st_nxt.rx = RX_IDLE;
					end else begin
						st_nxt.rx_first = 1'b0;
						st_nxt.rx_sh = {st_r.rx_sh[8:0], rx_bit};
						if (rx_fin) begin
							st_nxt.rx = RX_IDLE;
							if (store_ok) begin
								st_nxt.rxbuf = rx_data;
								st_nxt.rb8 = rx_ninth;
								st_nxt.ri = 1'b1;
							end
						end
					end
				end
			end
		endcase
		// Pin drive from the next state so pins come straight from flops
		st_nxt.pins.port_three_line_zero_oe = (st_nxt.mode == FMSP_SYNC) && (st_nxt.tx == TX_DATA);
		st_nxt.pins.port_three_line_zero_out = st_nxt.tx_sh[0];
		if (st_nxt.mode == FMSP_SYNC) begin
			st_nxt.pins.port_three_line_one_out = !(st_nxt.tx == TX_DATA || st_nxt.rx == RX_SHIFT)
				|| (st_nxt.div12 >= `FMSP_MC_HALF);
		end else begin
			st_nxt.pins.port_three_line_one_out = (st_nxt.tx == TX_DATA) ? st_nxt.tx_sh[0]
				: (st_nxt.tx != TX_START);
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.pins.port_three_line_one_out <= 1'b1;
			// Input synchroniser and edge detector start at the idle line level
			st_r.rx_meta <= 1'b1;
			st_r.rx_s <= 1'b1;
			st_r.rx_prev <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign axi_rsp = st_r.rsp;
	assign pins = st_r.pins;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sync_oe_a: assert property (st_r.pins.port_three_line_zero_oe |->
		st_r.mode == FMSP_SYNC && st_r.tx == TX_DATA) else $error("line zero driven outside sync send");
	sync_send_a: assert property (@(posedge clk) disable iff (rst || wr_data)
		st_r.mode == FMSP_SYNC && st_r.tx == TX_WAIT && mc |=> st_r.tx == TX_START ##12 st_r.tx == TX_DATA)
		else $error("sync send not one machine cycle after write");
	sync_shift_a: assert property (st_r.mode == FMSP_SYNC && st_r.tx == TX_DATA && mc && !tx_last
		&& !wr_data |=> st_r.tx_sh == {1'b0, $past(st_r.tx_sh[9:1])}) else $error("sync shift wrong");
	sync_done_a: assert property (st_r.mode == FMSP_SYNC && st_r.tx == TX_DATA && mc && tx_last
		&& !wr_data |=> st_r.ti && st_r.tx == TX_IDLE) else $error("sync transmit end wrong");
	rx0_load_a: assert property (st_r.rx == RX_LOAD && mc |=>
		st_r.rx == RX_SHIFT && st_r.rx_sh[7:0] == `FMSP_RX0_INIT) else $error("sync receive load wrong");
	rx_edge_a: assert property (st_r.rx == RX_IDLE && st_r.ren && st_r.mode != FMSP_SYNC && tick
		&& st_r.rx_prev && !st_r.rx_s |=> st_r.rx == RX_BIT && st_r.rx_cnt == 4'h0
		&& st_r.rx_sh[8:0] == `FMSP_RX_INIT) else $error("falling edge not caught");
	false_start_a: assert property (st_r.rx == RX_BIT && tick && st_r.rx_first
		&& st_r.rx_cnt == `FMSP_CNT_LAST && rx_bit |=> st_r.rx == RX_IDLE && $stable(st_r.rxbuf))
		else $error("false start accepted");
	store_a: assert property (rx_fin && store_ok |=>
		st_r.ri && st_r.rxbuf == $past(rx_data) && st_r.rb8 == $past(rx_ninth)) else $error("frame not stored");
	discard_a: assert property (rx_fin && !store_ok |=>
		$stable(st_r.rxbuf) && st_r.rx == RX_IDLE) else $error("frame not discarded");
	start_roll_a: assert property (st_r.tx == TX_WAIT && st_r.mode != FMSP_SYNC && !roll
		|=> st_r.tx != TX_START) else $error("frame began off rollover");
	start_low_a: assert property (st_r.tx == TX_START && st_r.mode != FMSP_SYNC |->
		!st_r.pins.port_three_line_one_out) else $error("start bit not low");
	fixed_rate_a: assert property (@(posedge clk) disable iff (rst || wr_go)
		st_r.mode == FMSP_FIXED9 && !st_r.dbl && tick |=> !tick ##1 tick) else $error("fixed rate tick spacing wrong");
	tx_done_a: assert property ($rose(st_r.ti) && st_r.mode != FMSP_SYNC && !$past(wr_ctrl)
		|-> $past(st_r.tx) == TX_STOP) else $error("tx done set early");

	// Rate sources: timer pulses and the slow fixed divisor
	fixed_slow_a: assert property (@(posedge clk) disable iff (rst || wr_go)
		st_r.mode == FMSP_FIXED9 && st_r.dbl && tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
		else $error("slow fixed rate tick spacing wrong");
	timer_a_rate_a: assert property (st_r.mode == FMSP_ASYNC8 && !st_r.tsel && !wr_go
		|=> st_r.tx_cnt == $past(st_r.tx_cnt) + {3'h0, $past(tmr_a_ovf)}) else $error("timer a not the tick");
	timer_b_rate_a: assert property (st_r.mode == FMSP_VAR9 && st_r.tsel && !wr_go
		|=> st_r.tx_cnt == $past(st_r.tx_cnt) + {3'h0, $past(tmr_b_ovf)}) else $error("timer b not the tick");

	// Transmit load on a buffer write
	tx_load_a: assert property (wr_data |=>
		st_r.tx == TX_WAIT && st_r.tx_sh[7:0] == st_r.wdata) else $error("transmit byte not loaded");
	marker_load_a: assert property (wr_data && !nine |=>
		st_r.tx_sh[9:8] == 2'b01) else $error("marker not above data");
	ninth_load_a: assert property (wr_data && nine |=>
		st_r.tx_sh[9] && st_r.tx_sh[8] == st_r.tb8) else $error("ninth bit not from flag");

	// Sync transmit pins and timing
	sync_wait_a: assert property (st_r.tx == TX_WAIT && st_r.mode == FMSP_SYNC && !mc && !wr_data
		|=> st_r.tx == TX_WAIT) else $error("sync send left wait early");
	sync_drive_a: assert property (st_r.mode == FMSP_SYNC && st_r.tx == TX_DATA |->
		st_r.pins.port_three_line_zero_oe && st_r.pins.port_three_line_zero_out == st_r.tx_sh[0])
		else $error("line zero not driven by shift output");
	sync_clk_a: assert property (st_r.mode == FMSP_SYNC && st_r.tx == TX_DATA |->
		st_r.pins.port_three_line_one_out == (st_r.div12 >= `FMSP_MC_HALF)) else $error("shift clock phase wrong");

	// Async transmit frame
	async_start_a: assert property (st_r.tx == TX_WAIT && st_r.mode != FMSP_SYNC && roll && !wr_data
		|=> st_r.tx == TX_START) else $error("frame not begun at rollover");
	data_out_a: assert property (st_r.tx == TX_DATA && st_r.mode != FMSP_SYNC |->
		st_r.pins.port_three_line_one_out == st_r.tx_sh[0]) else $error("line one not shift output");
	async_shift_a: assert property (st_r.tx == TX_DATA && st_r.mode != FMSP_SYNC && roll && !wr_data
		|=> st_r.tx_sh == {1'b0, $past(st_r.tx_sh[9:1])}) else $error("async shift wrong");
	async_end_a: assert property (st_r.tx == TX_DATA && st_r.mode != FMSP_SYNC && roll && tx_last
		&& !wr_data && !wr_ctrl |=> st_r.tx == TX_STOP) else $error("async frame end wrong");
	stop_high_a: assert property (st_r.tx == TX_STOP && st_r.mode != FMSP_SYNC |->
		st_r.pins.port_three_line_one_out) else $error("stop bit not high");
	idle_high_a: assert property (st_r.tx == TX_IDLE && st_r.mode != FMSP_SYNC |->
		st_r.pins.port_three_line_one_out) else $error("async line not idle high");

	// Receive paths
	rx_start_a: assert property (st_r.rx == RX_IDLE && st_r.ren && !st_r.ri && st_r.mode == FMSP_SYNC
		|=> st_r.rx == RX_LOAD) else $error("sync receive not started");
	rx_off_a: assert property (st_r.rx == RX_IDLE && !st_r.ren |=>
		st_r.rx == RX_IDLE) else $error("receive started while disabled");
	rx_shift0_a: assert property (st_r.rx == RX_SHIFT && mc && st_r.rx_sh[7] |=> st_r.rx == RX_SHIFT
		&& st_r.rx_sh[7:0] == {$past(st_r.rx_sh[6:0]), $past(st_r.rx_s)}) else $error("sync receive shift wrong");
	rx_store0_a: assert property (st_r.rx == RX_SHIFT && mc && !st_r.rx_sh[7] |=> st_r.ri
		&& st_r.rxbuf[0] == $past(st_r.rx_sh[6]) && st_r.rxbuf[7] == $past(st_r.rx_s))
		else $error("sync byte not stored");
	rx_sample_a: assert property (st_r.rx == RX_BIT && tick && st_r.rx_cnt == 4'h8 |=>
		st_r.rx_smp[0] == $past(st_r.rx_s)) else $error("mid bit sample missed");
	rx_nosample_a: assert property (st_r.rx == RX_BIT && tick && st_r.rx_cnt == 4'hC |=>
		$stable(st_r.rx_smp)) else $error("sample taken outside window");

	// Register bus answers stand until taken
	b_hold_a: assert property (st_r.rsp.bvalid && !axi_req.bready |=>
		st_r.rsp.bvalid && $stable(st_r.rsp.bresp)) else $error("write response dropped");
	r_hold_a: assert property (st_r.rsp.rvalid && !axi_req.rready |=>
		st_r.rsp.rvalid && $stable(st_r.rsp.rdata)) else $error("read data dropped");

	sync_tx_c: cover property (st_r.mode == FMSP_SYNC && st_r.tx == TX_DATA ##1 $rose(st_r.ti));
	sync_rx_c: cover property (st_r.rx == RX_SHIFT ##1 $rose(st_r.ri));
	async_store_c: cover property (rx_fin && store_ok);
	async_tx_c: cover property (st_r.tx == TX_STOP && st_r.mode != FMSP_SYNC ##1 $rose(st_r.ti));
	false_start_c: cover property (st_r.rx == RX_BIT && st_r.rx_first && tick && rx_bit
		&& st_r.rx_cnt == `FMSP_CNT_LAST);
endmodule
`default_nettype wire

//--- tb/fmsp_remote.sv
// Far-side serial partner: sends and captures frames on the two serial lines.
// Assumes the bench gives bit times in clk cycles and calls its tasks after a clk edge.
`timescale 1ns/1ps
`default_nettype none
module fmsp_remote (
	// Clock
	input wire logic clk,
	// Lines seen from the device
	input wire logic zero_in,
	input wire logic one_in,
	// Line driven toward the device
	output var logic zero_out
);
	// Async line idles high
	initial zero_out = 1'b1;
	// Frame out, LSB first, each bit held one bit time; frames end on the high stop bit
	task automatic send(input logic [10:0] f, input int n, input int bt);
		for (int i = 0; i < n; i++) begin
			zero_out <= f[i];
			repeat (bt) @(posedge clk);
		end
		// Half a bit of idle so the receiver finishes its last bit time
		repeat (bt / 2) @(posedge clk);
	endtask
	// Frame in, sampled mid bit after the start edge
	task automatic grab(output logic [10:0] f, input int n, input int bt);
		f = '0;
		@(negedge one_in);
		repeat (bt / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			f[i] = one_in;
			repeat (bt) @(posedge clk);
		end
	endtask
	// Shift-register byte in, taken on rising shift clock
	task automatic sgrab(output logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(posedge one_in);
			d[i] = zero_in;
		end
	endtask
	// Shift-register byte out, new bit on each falling shift clock, then back to idle
	task automatic ssend(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(negedge one_in);
			zero_out <= d[i];
		end
		repeat (14) @(posedge clk);
		zero_out <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the four-mode serial port over its register bus.
// Assumes a 10 MHz clk, timer pulses every 3 and 5 clk, and the partner on the lines.
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_defs.svh"
module testbench import fmsp_pkg::*; ;
	localparam logic [3:0] a_dat = `FMSP_ADDR_DATA;
	localparam logic [3:0] a_ctl = `FMSP_ADDR_CTRL;
	localparam logic [3:0] a_rate = `FMSP_ADDR_RATE;
	logic clk, rst, rem_lz, tmr_a, tmr_b, lz;
	fmsp_axi_req_s req;
	fmsp_axi_rsp_s rsp;
	fmsp_pins_s pins;
	int n_fail, checked, bt, nb;
	int tc = 0;
	logic [31:0] seed, rv, rr;
	logic [1:0] rs;
	logic [10:0] fr;
	logic [7:0] sb;
	logic [1:0] cm [5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h3};
	logic [1:0] cr [5] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h2};
	int cb [5] = '{32, 64, 48, 80, 80};

	// Line zero: device wins while its enable is high
	assign lz = pins.port_three_line_zero_oe ? pins.port_three_line_zero_out : rem_lz;
	fmsp_top fmsp_top_inst (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .port_three_line_zero_in(lz),
		.pins(pins), .tmr_a_ovf(tmr_a), .tmr_b_ovf(tmr_b));
	fmsp_remote fmsp_remote_inst (.clk(clk), .zero_in(lz), .one_in(pins.port_three_line_one_out), .zero_out(rem_lz));

	// Clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Timer overflow pulses: bit times of 48 and 80 clk
	always @(posedge clk) begin
		tc <= tc + 1;
		tmr_a <= (tc % 3 == 0);
		tmr_b <= (tc % 5 == 0);
	end
	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected frame bits, start bit first
	function automatic logic [10:0] frm(input logic [7:0] d, input logic b9, input int n);
		return (n == 11) ? {1'b1, b9, d, 1'b0} : {2'b01, d, 1'b0};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Bus write: both halves offered, each dropped once taken, then the response
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic ga, gw, ta, tw;
		ga = 1'b0;
		gw = 1'b0;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		while (!(ga && gw)) begin
			@(negedge clk);
			ta = rsp.awready && !ga;
			tw = rsp.wready && !gw;
			@(posedge clk);
			if (ta) req.awvalid <= 1'b0;
			if (tw) req.wvalid <= 1'b0;
			ga |= ta;
			gw |= tw;
		end
		ta = 1'b0;
		while (!ta) begin
			@(negedge clk);
			ta = rsp.bvalid;
			@(posedge clk);
		end
		req.bready <= 1'b0;
	endtask
	// Bus read
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t;
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		t = 1'b0;
		while (!t) begin
			@(negedge clk);
			t = rsp.arready;
			@(posedge clk);
		end
		req.arvalid <= 1'b0;
		t = 1'b0;
		while (!t) begin
			@(negedge clk);
			t = rsp.rvalid;
			d = rsp.rdata;
			r = rsp.rresp;
			@(posedge clk);
		end
		req.rready <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask

	// Main sequence
	initial begin
		seed = 32'd30738;
		n_fail = 0;
		checked = 0;
		req = '0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(a_ctl, 32'h0);
		rdc(a_rate, 32'h0);
		rd(4'hC, rv, rs);
		chk({30'h0, rs}, {30'h0, `FMSP_RESP_SLVERR});
		$display("test reset done");
		// Shift-register mode: send a byte, then take one in
		rv = rnd();
		fork
			fmsp_remote_inst.sgrab(sb);
			wr(a_dat, {24'h0, rv[7:0]});
		join
		chk({24'h0, sb}, {24'h0, rv[7:0]});
		repeat (12) @(posedge clk);
		rdc(a_ctl, 32'h2);
		rv = rnd();
		fork
			fmsp_remote_inst.ssend(rv[7:0]);
			wr(a_ctl, 32'h10);
		join
		rdc(a_dat, {24'h0, rv[7:0]});
		rdc(a_ctl, 32'h11);
		$display("test shift mode done");
		// Async modes at each rate source: send, receive, drop while done flag set
		for (int k = 0; k < 5; k++) begin
			bt = cb[k];
			nb = cm[k][1] ? 11 : 10;
			rv = rnd();
			rr = rnd();
			wr(a_rate, {30'h0, cr[k]});
			wr(a_ctl, {24'h0, cm[k], 2'b01, rv[8], 3'b000});
			fork
				fmsp_remote_inst.grab(fr, nb, bt);
				wr(a_dat, {24'h0, rv[7:0]});
			join
			chk({21'h0, fr}, {21'h0, frm(rv[7:0], rv[8], nb)});
			rdc(a_ctl, {24'h0, cm[k], 2'b01, rv[8], 3'b010});
			fmsp_remote_inst.send(frm(rr[7:0], rr[8], nb), nb, bt);
			rdc(a_dat, {24'h0, rr[7:0]});
			rdc(a_ctl, {24'h0, cm[k], 2'b01, rv[8], (nb == 11) ? rr[8] : 1'b1, 2'b11});
			fmsp_remote_inst.send(frm(~rr[7:0], rr[8], nb), nb, bt);
			rdc(a_dat, {24'h0, rr[7:0]});
			$display("test async %0d done", k);
		end
		// Filter on: ninth bit low is dropped, high is stored; filter off: a short low pulse is no start
		wr(a_rate, 32'h0);
		wr(a_ctl, 32'hB0);
		fmsp_remote_inst.send(frm(8'hA5, 1'b0, 11), 11, 32);
		rdc(a_ctl, 32'hB0);
		fmsp_remote_inst.send(frm(8'h3C, 1'b1, 11), 11, 32);
		rdc(a_dat, 32'h3C);
		wr(a_ctl, 32'h90);
		fmsp_remote_inst.send(11'h000, 1, 4);
		fmsp_remote_inst.send(11'h7FF, 1, 32);
		fmsp_remote_inst.send(frm(8'h5A, 1'b0, 11), 11, 32);
		rdc(a_dat, 32'h5A);
		rdc(a_ctl, 32'h91);
		$display("test filter done");
		test_done();
	end
	// Watchdog
	initial begin
		repeat (80000) @(posedge clk);
		n_fail++;
		test_done();
	end
endmodule
`default_nettype wire
